// [design/ppm_pkg.sv]
// Package: register map, field layout, reset values and states of the port
package ppm_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses within the slave window; the buffer bases give the upper nibble)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_ADDR  = 8'h04;
	localparam logic [7:0] OFS_DATA  = 8'h08;
	localparam logic [7:0] OFS_CSEL  = 8'h0c;
	localparam logic [7:0] OFS_STAT  = 8'h10;
	localparam logic [7:0] OFS_MASK  = 8'h14;
	localparam logic [3:0] OFS_OBUF  = 4'h2;
	localparam logic [3:0] OFS_IBUF  = 4'h3;

	// ------------------------------------------------------------
	// Fields of port_mode_config
	// ------------------------------------------------------------
	localparam int BUSY_BIT  = 15;
	localparam int IRQ_LSB   = 13;
	localparam int STEP_LSB  = 11;
	localparam int WIDTH_BIT = 10;
	localparam int MODE_LSB  = 8;
	localparam int SETUP_LSB = 6;
	localparam int MAIN_LSB  = 2;
	localparam int END_LSB   = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [14:0] MODE_RST = 15'h0000;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [1:0]  CSEL_RST = 2'h0;
	localparam logic [1:0]  STAT_RST = 2'h0;
	localparam logic [1:0]  MASK_RST = 2'h0;

	// Status bits: port event and master transfer done
	localparam int ST_PORT = 0;
	localparam int ST_DONE = 1;

	typedef enum logic [1:0] {
		PM_LEGACY   = 2'b00,
		PM_ENHANCED = 2'b01,
		PM_MASTER2  = 2'b10,
		PM_MASTER1  = 2'b11
	} ppm_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_END    = 2'b11
	} ppm_state_t;

endpackage : ppm_pkg

// [design/ppm_mode_ctrl.sv]
// Parallel port mode control with AHB-Lite register slave
// Operation
// - Bit 15 of the mode register reads as the master busy flag.
// - Trigger 01 interrupts at each cycle end, trigger 00 never sets the port event.
// - Trigger 10 interrupts on buffer 3 access or slave address 11.
// - Address step 01 adds one, 10 subtracts one, 00 holds the address.
// - Address step 11 auto-advances the legacy slave buffers.
// - Address bits used as chip selects never step.
// - Each data register access in a master mode while not busy makes one 8-bit or 16-bit transfer, except a read in the cycle of a write launch.
// - Mode 11 is master with direction line and enable strobe.
// - Mode 10 is master with separate read and write strobes.
// - Mode 01 is an addressed slave using two address lines.
// - Mode 00 is a legacy slave without address lines.
// - Setup wait code adds one to four cycles before the strobe.
// - Main wait 0000 forces short setup and end phases.
// - Upper data lines are driven only in 16-bit master transfers.
// - Mode register bits 31 to 16 read zero and ignore writes.
`timescale 1ns/100ps

module ppm_mode_ctrl (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Interrupt
	output logic             irq,
	// Port pins, master side
	output logic             first_chip_select,
	output logic             second_chip_select,
	output logic             read_strobe_out,
	output logic             write_strobe_out,
	output logic             enable_strobe,
	output logic [15:0]      port_address_out,
	// Port pins, slave side
	input  wire logic        slave_chip_select,
	input  wire logic        read_strobe_in,
	input  wire logic        write_strobe_in,
	input  wire logic [1:0]  port_address_in,
	// Shared data lines
	input  wire logic [15:0] port_data_in,
	output logic [15:0]      port_data_out,
	output logic [15:0]      port_data_oe
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic buf_hit(input logic [7:0] ofs,
	                                 input logic [3:0] base);
		buf_hit = (ofs[7:4] == base) && (ofs[1:0] == 2'b00);
	endfunction : buf_hit

	function automatic logic [15:0] step_addr(input logic [15:0] a,
	                                          input logic [1:0]  step,
	                                          input logic [1:0]  csel);
		logic [15:0] n;
		n = a;
		if (step == 2'b01)
			n = a + 16'h0001;
		else if (step == 2'b10)
			n = a - 16'h0001;
		if (csel[1])
			n[15] = a[15];
		if (csel[0])
			n[14] = a[14];
		step_addr = n;
	endfunction : step_addr

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [14:0]          mode_reg;
	logic                 busy;
	logic [15:0]          addr_reg;
	logic [1:0]           csel;
	logic [1:0]           status;
	logic [1:0]           mask;
	logic [15:0]          rd_data;
	logic [15:0]          tx_data;
	logic                 is_read;
	logic [4:0]           cnt;
	ppm_pkg::ppm_state_t  state;
	ppm_pkg::ppm_state_t  next_state;
	logic [7:0]           out_buf [0:3];
	logic [7:0]           in_buf  [0:3];
	logic [1:0]           rd_ptr;
	logic [1:0]           wr_ptr;
	logic                 wr_pend;
	logic [7:0]           wr_ofs;
	logic [20:0]          sync1;
	logic [20:0]          sync2;
	logic                 prev_rd;
	logic                 prev_wr;
	logic                 prev_cs;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire [1:0] f_irq   = mode_reg[ppm_pkg::IRQ_LSB +: 2];
	wire [1:0] f_step  = mode_reg[ppm_pkg::STEP_LSB +: 2];
	wire       f_wide  = mode_reg[ppm_pkg::WIDTH_BIT];
	wire [1:0] f_mode  = mode_reg[ppm_pkg::MODE_LSB +: 2];
	wire [1:0] f_setup = mode_reg[ppm_pkg::SETUP_LSB +: 2];
	wire [3:0] f_main  = mode_reg[ppm_pkg::MAIN_LSB +: 4];
	wire [1:0] f_end   = mode_reg[ppm_pkg::END_LSB +: 2];
	wire       master  = f_mode[1];
	wire       m_one   = (f_mode == ppm_pkg::PM_MASTER1);
	wire       enh     = (f_mode == ppm_pkg::PM_ENHANCED);
	wire       legacy  = (f_mode == ppm_pkg::PM_LEGACY);
	wire       fast    = (f_main == 4'h0);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire       ap      = hsel && htrans[1] && hready;
	wire [7:0] ofs     = haddr[7:0];
	wire       w_mode  = wr_pend && (wr_ofs == ppm_pkg::OFS_MODE);
	wire       w_addr  = wr_pend && (wr_ofs == ppm_pkg::OFS_ADDR);
	wire       w_data  = wr_pend && (wr_ofs == ppm_pkg::OFS_DATA);
	wire       w_csel  = wr_pend && (wr_ofs == ppm_pkg::OFS_CSEL);
	wire       w_stat  = wr_pend && (wr_ofs == ppm_pkg::OFS_STAT);
	wire       w_mask  = wr_pend && (wr_ofs == ppm_pkg::OFS_MASK);
	wire       w_obuf  = wr_pend && buf_hit(wr_ofs, ppm_pkg::OFS_OBUF);
	wire       r_data  = ap && !hwrite && (ofs == ppm_pkg::OFS_DATA);

	// Reserved upper half of the mode register reads zero
	wire [31:0] rd_val =
		(ofs == ppm_pkg::OFS_MODE) ? {16'h0000, busy, mode_reg} :
		(ofs == ppm_pkg::OFS_ADDR) ? {16'h0000, addr_reg} :
		(ofs == ppm_pkg::OFS_DATA) ? {16'h0000, rd_data} :
		(ofs == ppm_pkg::OFS_CSEL) ? {30'h0, csel} :
		(ofs == ppm_pkg::OFS_STAT) ? {30'h0, status} :
		(ofs == ppm_pkg::OFS_MASK) ? {30'h0, mask} :
		buf_hit(ofs, ppm_pkg::OFS_OBUF) ? {24'h0, out_buf[ofs[3:2]]} :
		buf_hit(ofs, ppm_pkg::OFS_IBUF) ? {24'h0, in_buf[ofs[3:2]]} :
		32'h0000_0000;

	// ------------------------------------------------------------
	// Master transfer launch and timing
	// ------------------------------------------------------------
	// A write launch wins over a read launch in the same cycle
	wire launch_wr = w_data && master && !busy;
	wire launch_rd = r_data && master && !busy && !launch_wr;
	wire launch    = launch_wr || launch_rd;
	wire next_rd   = launch ? launch_rd : is_read;

	wire [4:0] setup_len = fast ? 5'd1 : {3'b000, f_setup} + 5'd1;
	wire [4:0] strb_len  = {1'b0, f_main} + 5'd1;
	wire [4:0] end_len   = fast ? (is_read ? 5'd0 : 5'd1)
	                            : {3'b000, f_end} + 5'd1;
	wire       strb_last = (state == ppm_pkg::ST_STROBE) && (cnt == 5'd0);
	wire       end_last  = (state == ppm_pkg::ST_END) && (cnt == 5'd0);
	wire       done      = end_last || (strb_last && (end_len == 5'd0));

	always_comb begin
		next_state = state;
		case (state)
			ppm_pkg::ST_IDLE: begin
				if (launch)
					next_state = ppm_pkg::ST_SETUP;
			end
			ppm_pkg::ST_SETUP: begin
				if (cnt == 5'd0)
					next_state = ppm_pkg::ST_STROBE;
			end
			ppm_pkg::ST_STROBE: begin
				if (cnt == 5'd0)
					next_state = (end_len == 5'd0) ? ppm_pkg::ST_IDLE
					                               : ppm_pkg::ST_END;
			end
			ppm_pkg::ST_END: begin
				if (cnt == 5'd0)
					next_state = ppm_pkg::ST_IDLE;
			end
			default: next_state = ppm_pkg::ST_IDLE;
		endcase
	end

	wire [4:0] next_cnt =
		(state == ppm_pkg::ST_IDLE) ? setup_len - 5'd1 :
		(cnt != 5'd0) ? cnt - 5'd1 :
		(state == ppm_pkg::ST_SETUP) ? strb_len - 5'd1 :
		(end_len == 5'd0) ? 5'd0 : end_len - 5'd1;

	// ------------------------------------------------------------
	// Slave side decode (pins pass two flip-flops first)
	// ------------------------------------------------------------
	wire        s_cs   = sync2[0];
	wire        s_rd   = sync2[1];
	wire        s_wr   = sync2[2];
	wire [1:0]  s_addr = sync2[4:3];
	wire [15:0] s_data = sync2[20:5];
	wire        buffered = legacy && (f_step == 2'b11);
	wire [1:0]  rd_idx = enh ? s_addr : (buffered ? rd_ptr : 2'b00);
	wire [1:0]  wr_idx = enh ? s_addr : (buffered ? wr_ptr : 2'b00);
	wire        rd_end = !master && prev_rd && prev_cs && !s_rd;
	wire        wr_end = !master && prev_wr && prev_cs && !s_wr;
	wire        s_read = !master && s_cs && s_rd;

	// Trigger 10 differs by slave mode; 11 is reserved and stays silent
	wire ev_t1 = (f_irq == 2'b01) && (done || rd_end || wr_end);
	wire ev_t2 = (f_irq == 2'b10) &&
		((buffered && ((rd_end && rd_ptr == 2'b11) ||
		               (wr_end && wr_ptr == 2'b11))) ||
		 (enh && (rd_end || wr_end) && s_addr == 2'b11));
	wire [1:0] ev = {done, ev_t1 || ev_t2};
	// Set wins over a one written to clear
	wire [1:0] next_status = (status & ~(w_stat ? hwdata[1:0] : 2'b00)) | ev;

	// ------------------------------------------------------------
	// Pin output values
	// ------------------------------------------------------------
	wire        n_act   = (next_state != ppm_pkg::ST_IDLE) && master;
	wire        n_strb  = (next_state == ppm_pkg::ST_STROBE) && master;
	wire        m_drive = n_act && !next_rd;
	wire [7:0]  hi_oe   = f_wide ? 8'hff : 8'h00;
	wire [15:0] next_do = m_drive ? {tx_data[15:8] & hi_oe, tx_data[7:0]} :
	                      s_read ? {8'h00, out_buf[rd_idx]} : 16'h0000;
	wire [15:0] next_oe = m_drive ? {hi_oe, 8'hff} :
	                      s_read ? 16'h00ff : 16'h0000;

	// ------------------------------------------------------------
	// Bus slave flops
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend   <= 1'b0;
			wr_ofs    <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= (ap && !hwrite) ? rd_val : 32'h0000_0000;
			wr_pend   <= ap && hwrite;
			wr_ofs    <= ofs;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= ppm_pkg::MODE_RST;
			csel     <= ppm_pkg::CSEL_RST;
			mask     <= ppm_pkg::MASK_RST;
			status   <= ppm_pkg::STAT_RST;
			irq      <= 1'b0;
			addr_reg <= ppm_pkg::ADDR_RST;
		end else begin
			if (w_mode)
				mode_reg <= hwdata[14:0];
			if (w_csel)
				csel <= hwdata[1:0];
			if (w_mask)
				mask <= hwdata[1:0];
			status <= next_status;
			irq    <= |(next_status & mask);
			if (w_addr)
				addr_reg <= hwdata[15:0];
			else if (done)
				addr_reg <= step_addr(addr_reg, f_step, csel);
		end
	end

	// ------------------------------------------------------------
	// Master sequencer
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state   <= ppm_pkg::ST_IDLE;
			cnt     <= 5'd0;
			busy    <= 1'b0;
			is_read <= 1'b0;
			tx_data <= 16'h0000;
			rd_data <= 16'h0000;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			busy    <= launch || (busy && !done);
			is_read <= next_rd;
			if (launch_wr)
				tx_data <= hwdata[15:0];
			// Data pins lag two cycles through the synchroniser
			if (strb_last && is_read)
				rd_data <= {s_data[15:8] & hi_oe, s_data[7:0]};
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_chip_select  <= 1'b0;
			second_chip_select <= 1'b0;
			read_strobe_out    <= 1'b0;
			write_strobe_out   <= 1'b0;
			enable_strobe      <= 1'b0;
			port_address_out   <= 16'h0000;
			port_data_out      <= 16'h0000;
			port_data_oe       <= 16'h0000;
		end else begin
			first_chip_select  <= n_act && csel[0] && addr_reg[14];
			second_chip_select <= n_act && csel[1] && addr_reg[15];
			// Mode 11: direction level plus enable; mode 10: two strobes
			read_strobe_out  <= m_one ? (n_act && next_rd)
			                          : (n_strb && next_rd);
			write_strobe_out <= !m_one && n_strb && !next_rd;
			enable_strobe    <= m_one && n_strb;
			port_address_out <= addr_reg;
			port_data_out    <= next_do;
			port_data_oe     <= next_oe;
		end
	end

	// ------------------------------------------------------------
	// Slave pins and buffers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1   <= 21'h0;
			sync2   <= 21'h0;
			prev_rd <= 1'b0;
			prev_wr <= 1'b0;
			prev_cs <= 1'b0;
			rd_ptr  <= 2'b00;
			wr_ptr  <= 2'b00;
		end else begin
			sync1   <= {port_data_in, port_address_in, write_strobe_in,
			            read_strobe_in, slave_chip_select};
			sync2   <= sync1;
			prev_rd <= s_rd;
			prev_wr <= s_wr;
			prev_cs <= s_cs;
			if (!buffered) begin
				rd_ptr <= 2'b00;
				wr_ptr <= 2'b00;
			end else begin
				if (rd_end)
					rd_ptr <= rd_ptr + 2'b01;
				if (wr_end)
					wr_ptr <= wr_ptr + 2'b01;
			end
		end
	end

	// Buffers hold data only; no reset needed
	always_ff @(posedge hclk) begin
		if (w_obuf)
			out_buf[wr_ofs[3:2]] <= hwdata[7:0];
		if (wr_end)
			in_buf[wr_idx] <= s_data[7:0];
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_UPPER_ZERO: assert property (
		ap && !hwrite && ofs == ppm_pkg::OFS_MODE |=> hrdata[31:16] == 16'h0)
		else $error("mode register upper half not zero");
	AST_BUSY_READ: assert property (
		ap && !hwrite && ofs == ppm_pkg::OFS_MODE |=> hrdata[15] == $past(busy))
		else $error("busy bit does not match busy state");
	AST_BUSY_SPAN: assert property (
		launch |=> busy && state == ppm_pkg::ST_SETUP)
		else $error("busy not raised at launch");
	AST_NO_IRQ: assert property (
		f_irq == 2'b00 |-> !ev[ppm_pkg::ST_PORT])
		else $error("port event with trigger off");
	AST_IRQ_END: assert property (
		done && f_irq == 2'b01 |=> status[ppm_pkg::ST_PORT])
		else $error("cycle end did not set status");
	AST_STEP_INC: assert property (
		done && !w_addr && f_step == 2'b01 && csel == 2'b00
		|=> addr_reg == $past(addr_reg) + 16'h0001)
		else $error("address did not increment");
	AST_CS_HOLD: assert property (
		done && csel == 2'b11 |=> addr_reg[15:14] == $past(addr_reg[15:14]))
		else $error("chip select address bits stepped");
	AST_SETUP4: assert property (
		launch && !fast && f_setup == 2'b11
		|=> (state == ppm_pkg::ST_SETUP) [*4] ##1 state == ppm_pkg::ST_STROBE)
		else $error("setup phase not four cycles");
	AST_FAST_RD: assert property (
		launch_rd && fast |=> state == ppm_pkg::ST_SETUP
		##1 state == ppm_pkg::ST_STROBE ##1 state == ppm_pkg::ST_IDLE)
		else $error("fast read timing wrong");
	AST_UPPER_OE: assert property (
		!f_wide |=> port_data_oe[15:8] == 8'h00)
		else $error("upper data lines driven in 8-bit mode");
	AST_MODE1: assert property (
		m_one && state == ppm_pkg::ST_STROBE && $stable(f_mode)
		|-> enable_strobe && !write_strobe_out)
		else $error("mode 11 strobe wrong");
	AST_MODE2: assert property (
		f_mode == ppm_pkg::PM_MASTER2 && state == ppm_pkg::ST_STROBE
		&& $stable(f_mode) |-> !enable_strobe
		&& (read_strobe_out == is_read) && (write_strobe_out == !is_read))
		else $error("mode 10 strobes wrong");
	AST_BUF_STEP: assert property (
		rd_end && buffered |=> rd_ptr == $past(rd_ptr) + 2'b01)
		else $error("read buffer pointer did not advance");

	COV_MASTER_WR: cover property (launch_wr ##[1:40] done);
	COV_MASTER_RD: cover property (launch_rd && m_one ##[1:40] done);
	COV_BUF3_IRQ:  cover property (ev_t2 ##1 irq);
	COV_ENH_WR:    cover property (enh && wr_end);

endmodule : ppm_mode_ctrl

// [bench/ppm_far_end.sv]
// Far end model: parallel memory peripheral answering master transfers
`timescale 1ns/100ps

module ppm_far_end (
	// Clock
	input  wire logic        hclk,
	// Master pins from the port
	input  wire logic        first_chip_select,
	input  wire logic        second_chip_select,
	input  wire logic        read_strobe_out,
	input  wire logic        write_strobe_out,
	input  wire logic        enable_strobe,
	input  wire logic [15:0] port_address_out,
	input  wire logic [15:0] port_data_out,
	input  wire logic [15:0] port_data_oe,
	// Answer and captured write
	output logic [15:0]      far_data,
	output logic [15:0]      last_wr,
	output logic [15:0]      last_oe,
	output logic [1:0]       last_cs
);
	// ------------------------------------------------------------
	// Read answer and write capture
	// ------------------------------------------------------------
	logic [15:0] junk = 16'h3c96;
	wire  [7:0]  adr  = port_address_out[7:0];
	wire         hit  = write_strobe_out | (enable_strobe & ~read_strobe_out);

	// Released lines toggle each cycle so stale data never looks valid
	assign far_data = read_strobe_out ? {~adr, adr} : junk;

	always @(posedge hclk) begin
		junk <= ~junk;
		if (hit) begin
			last_wr <= port_data_out & port_data_oe;
			last_oe <= port_data_oe;
			last_cs <= {second_chip_select, first_chip_select};
		end
	end
endmodule : ppm_far_end

// [bench/parallel_port_mode_control_tb.sv]
// Testbench: registers, master transfers and slave pins of the port
`timescale 1ns/100ps

module parallel_port_mode_control_tb;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0]  htrans, port_address_in, last_cs;
	logic [2:0]  hsize;
	logic        first_chip_select, second_chip_select, enable_strobe;
	logic        read_strobe_out, write_strobe_out, host_drv;
	logic        slave_chip_select, read_strobe_in, write_strobe_in;
	logic [15:0] port_address_out, port_data_in, port_data_out, host_d;
	logic [15:0] port_data_oe, far_data, last_wr, last_oe;
	int          n_fail, checks_done, oe_n, b;

	assign hready = hreadyout;
	assign port_data_in = host_drv ? host_d : far_data;

	ppm_mode_ctrl u_ppm_mode_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq,
		.first_chip_select, .second_chip_select, .read_strobe_out,
		.write_strobe_out, .enable_strobe, .port_address_out,
		.slave_chip_select, .read_strobe_in, .write_strobe_in,
		.port_address_in, .port_data_in, .port_data_out, .port_data_oe);

	ppm_far_end u_ppm_far_end (.hclk, .first_chip_select, .second_chip_select,
		.read_strobe_out, .write_strobe_out, .enable_strobe, .port_address_out,
		.port_data_out, .port_data_oe, .far_data, .last_wr, .last_oe, .last_cs);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Counts cycles the port drives the data lines
	always @(posedge hclk) if (port_data_oe[0] === 1'b1) oe_n <= oe_n + 1;

	// ------------------------------------------------------------
	// Bus and pin tasks
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		// Data and response are taken at the edge that ends the data phase
		rv = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Polls busy; a bounded poll keeps a stuck flag from hanging the run
	task automatic idle();
		int k;
		for (k = 0; k < 40; k++) begin
			rd(8'h00);
			if (rv[15] === 1'b0) break;
		end
		chk("busy clear", {31'h0, rv[15]}, 32'h0);
	endtask : idle

	function automatic logic [31:0] md(input logic [1:0] q, s, m,
		input logic w, input logic [1:0] bw, input logic [3:0] wm,
		input logic [1:0] we);
		return {17'h0, q, s, w, m, bw, wm, we};
	endfunction : md

	// Host write strobe stays 5 cycles each way, read strobe 6 high and 5 low; write data held past the fall
	task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
		slave_chip_select <= 1'b1;
		port_address_in <= a;
		host_d <= {8'h0, d};
		host_drv <= 1'b1;
		write_strobe_in <= 1'b1;
		repeat (5) @(posedge hclk);
		write_strobe_in <= 1'b0;
		repeat (5) @(posedge hclk);
		slave_chip_select <= 1'b0;
		host_drv <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : host_wr

	task automatic host_rd(input logic [1:0] a, input logic [7:0] d);
		slave_chip_select <= 1'b1;
		port_address_in <= a;
		read_strobe_in <= 1'b1;
		repeat (6) @(posedge hclk);
		chk("host rd", {port_data_oe[7:0], port_data_out[7:0]}, {8'hff, d});
		read_strobe_in <= 1'b0;
		repeat (5) @(posedge hclk);
		slave_chip_select <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : host_rd

	task automatic stop_test();
		$display("checks_done %0d n_fail %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	initial begin
		#400000;
		n_fail++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		{hresetn, hwrite, htrans, haddr, hwdata, host_drv, host_d} = '0;
		{slave_chip_select, read_strobe_in, write_strobe_in} = '0;
		{port_address_in, n_fail, checks_done, oe_n} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h00);
		chk("mode reset", rv, 32'h0);
		wr(8'h00, 32'hffffffff);
		rd(8'h00);
		chk("mode upper", rv, 32'h00007fff);
		rd(8'h18);
		chk("unmapped", rv, 32'h0);
		wr(8'h14, 32'h3);
		wr(8'h00, md(2'h1, 2'h1, 2'h2, 1'b0, 2'h0, 4'h0, 2'h0));
		wr(8'h04, 32'h00ff);
		wr(8'h10, 32'h3);
		oe_n = 0;
		wr(8'h08, 32'ha5c3);
		rd(8'h00);
		chk("busy", {31'h0, rv[15]}, 32'h1);
		idle();
		chk("short span", oe_n, 3);
		chk("wr8", last_wr, 16'h00c3);
		chk("wr8 oe", last_oe, 16'h00ff);
		rd(8'h04);
		chk("addr inc", rv, 32'h0100);
		rd(8'h10);
		chk("status", rv, 32'h3);
		chk("irq on", irq, 1'b1);
		wr(8'h14, 32'h0);
		rd(8'h10);
		chk("irq masked", irq, 1'b0);
		wr(8'h14, 32'h3);
		wr(8'h10, 32'h3);
		rd(8'h10);
		chk("status clr", rv, 32'h0);
		chk("irq clr", irq, 1'b0);
		// Short read: the read cycle end also steps and interrupts
		rd(8'h08);
		idle();
		rd(8'h10);
		chk("rd end", rv, 32'h3);
		wr(8'h10, 32'h3);
		for (b = 0; b < 4; b++) begin
			wr(8'h00, md(2'h0, 2'h0, 2'h2, 1'b1, b[1:0], 4'h1, 2'h0));
			oe_n = 0;
			wr(8'h08, 32'h1230 + b);
			idle();
			chk("setup span", oe_n, b + 4);
			chk("wr16", last_wr, 16'h1230 + b);
		end
		rd(8'h10);
		chk("no trigger", rv, 32'h2);
		rd(8'h04);
		chk("addr hold", rv, 32'h0101);
		wr(8'h0c, 32'h3);
		wr(8'h04, 32'hc000);
		wr(8'h00, md(2'h0, 2'h2, 2'h3, 1'b1, 2'h0, 4'h3, 2'h0));
		wr(8'h08, 32'h5a5a);
		idle();
		rd(8'h04);
		chk("cs keep", rv, 32'hffff);
		chk("cs pins", last_cs, 2'h3);
		chk("m1 data", last_wr, 16'h5a5a);
		wr(8'h0c, 32'h0);
		wr(8'h04, 32'h0012);
		rd(8'h08);
		idle();
		rd(8'h08);
		chk("rd16", rv, 32'hed12);
		idle();
		wr(8'h00, md(2'h0, 2'h2, 2'h3, 1'b0, 2'h0, 4'h3, 2'h0));
		rd(8'h08);
		chk("rd16 b", rv, 32'hee11);
		idle();
		rd(8'h08);
		chk("rd8", rv, 32'h0010);
		// The last data read launched one more transfer; let it finish
		idle();
		wr(8'h00, md(2'h2, 2'h0, 2'h1, 1'b0, 2'h0, 4'h0, 2'h0));
		wr(8'h24, 32'h9e);
		wr(8'h10, 32'h3);
		host_wr(2'h1, 8'h21);
		host_rd(2'h1, 8'h9e);
		rd(8'h10);
		chk("no event", rv, 32'h0);
		host_wr(2'h3, 8'h6b);
		rd(8'h10);
		chk("event a3", rv, 32'h1);
		rd(8'h3c);
		chk("ibuf3", rv, 32'h6b);
		rd(8'h34);
		chk("ibuf1", rv, 32'h21);
		wr(8'h00, md(2'h2, 2'h3, 2'h0, 1'b0, 2'h0, 4'h0, 2'h0));
		wr(8'h10, 32'h3);
		host_wr(2'h3, 8'h11);
		host_wr(2'h3, 8'h22);
		host_wr(2'h3, 8'h33);
		rd(8'h10);
		chk("buf2 quiet", rv, 32'h0);
		host_wr(2'h3, 8'h44);
		rd(8'h10);
		chk("buf3 event", rv, 32'h1);
		rd(8'h30);
		chk("legacy 0", rv, 32'h11);
		rd(8'h34);
		chk("legacy 1", rv, 32'h22);
		rd(8'h3c);
		chk("legacy 3", rv, 32'h44);
		stop_test();
	end
endmodule : parallel_port_mode_control_tb
